//--- src/ctp_timer_pair.sv
// Purpose: Two 16-bit timers that may cascade into one 32-bit timer, APB slave.
// Assumes: Single pclk domain; external clock and gate pins are asynchronous.
// Notes: Slave answers with zero wait states; pready is always high.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/10ps
module ctp_timer_pair (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and power state
  input wire logic ext_clk_low,
  input wire logic ext_clk_high,
  input wire logic ext_gate_low,
  input wire logic ext_gate_high,
  input wire logic cpu_idle,
  // Interrupt requests with priority
  output logic irq_low,
  output logic irq_high,
  output logic [2:0] irq_low_priority,
  output logic [2:0] irq_high_priority,
  // Time bases and ADC trigger
  output ctp_pkg::ctp_base_s base_low,
  output ctp_pkg::ctp_base_s base_high,
  output logic adc_trigger
);

  // Prescale field to terminal count
  function automatic logic [7:0] ps_limit(input logic [1:0] sel);
    case (sel)
      ctp_pkg::PS_8: ps_limit = ctp_pkg::DIV_8;
      ctp_pkg::PS_64: ps_limit = ctp_pkg::DIV_64;
      ctp_pkg::PS_256: ps_limit = ctp_pkg::DIV_256;
      default: ps_limit = ctp_pkg::DIV_1;
    endcase
  endfunction

  // Unpack a control word
  function automatic ctp_pkg::ctp_ctrl_s decode(input logic [15:0] w);
    decode.run = w[ctp_pkg::BIT_RUN];
    decode.idle_stop = w[ctp_pkg::BIT_IDLE_STOP];
    decode.gate = w[ctp_pkg::BIT_GATE];
    decode.prescale = w[ctp_pkg::BIT_PS_HI:ctp_pkg::BIT_PS_LO];
    decode.src = w[ctp_pkg::BIT_SRC];
  endfunction

  logic [15:0] low_ctrl_reg, high_ctrl_reg;
  logic [15:0] count_low_reg, count_high_reg;
  logic [15:0] period_low_reg, period_high_reg;
  logic [1:0] flag_reg, enable_reg;
  logic [5:0] prio_reg;
  logic [1:0] clk_s1, clk_s2, clk_s3, gate_s1, gate_s2;
  logic int_div_reg;
  logic [7:0] ps_low_reg, ps_high_reg;
  logic clear_low_reg, clear_high_reg;
  logic [31:0] prdata_next;
  ctp_pkg::ctp_mode_e mode;
  ctp_pkg::ctp_ctrl_s c_low, c_high;
  logic wr, rd;
  logic [1:0] src_pulse, gated_ok, active, in_tick, ps_tick;
  logic match_low, match_high, match_pair;
  logic [1:0] set_flag;

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Mode from bit 3 of the low control word
  assign mode = low_ctrl_reg[ctp_pkg::BIT_PAIR] ? ctp_pkg::CTP_PAIRED
                                                : ctp_pkg::CTP_SINGLE;
  assign c_low = decode(low_ctrl_reg);
  assign c_high = decode(high_ctrl_reg);

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= 2'h0;
      clk_s2 <= 2'h0;
      clk_s3 <= 2'h0;
      gate_s1 <= 2'h0;
      gate_s2 <= 2'h0;
    end else begin
      clk_s1 <= {ext_clk_high, ext_clk_low};
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      gate_s1 <= {ext_gate_high, ext_gate_low};
      gate_s2 <= gate_s1;
    end
  end

  // Internal clock enable at half the bus rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_div_reg <= 1'b0;
    end else begin
      int_div_reg <= int_div_reg ^ ctp_pkg::INT_DIV;
    end
  end

  // Source pulse and gating per timer; high side always uses its own inputs, unused when paired
  always_comb begin
    logic [1:0] ext_edge;
    ext_edge = clk_s2 & ~clk_s3;
    src_pulse[0] = c_low.src ? ext_edge[0] : int_div_reg;
    src_pulse[1] = c_high.src ? ext_edge[1] : int_div_reg;
    // Gate only matters with the internal source
    gated_ok[0] = c_low.src | ~c_low.gate | gate_s2[0];
    gated_ok[1] = c_high.src | ~c_high.gate | gate_s2[1];
    // Idle stops a timer only when its idle-stop bit is set; sleep never does
    active[0] = c_low.run & ~(cpu_idle & c_low.idle_stop);
    active[1] = c_high.run & ~(cpu_idle & c_high.idle_stop);
    in_tick[0] = active[0] & gated_ok[0] & src_pulse[0];
    in_tick[1] = active[1] & gated_ok[1] & src_pulse[1];
  end

  // Prescalers; in pair mode the low one drives both words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_low_reg <= 8'h00;
      ps_high_reg <= 8'h00;
    end else begin
      if (!c_low.run) begin
        ps_low_reg <= 8'h00;
      end else if (in_tick[0]) begin
        ps_low_reg <= (ps_low_reg >= ps_limit(c_low.prescale)) ? 8'h00
                                                               : ps_low_reg + 8'h01;
      end
      if (!c_high.run || mode == ctp_pkg::CTP_PAIRED) begin
        ps_high_reg <= 8'h00;
      end else if (in_tick[1]) begin
        ps_high_reg <= (ps_high_reg >= ps_limit(c_high.prescale)) ? 8'h00
                                                                  : ps_high_reg + 8'h01;
      end
    end
  end

  assign ps_tick[0] = in_tick[0] & (ps_low_reg >= ps_limit(c_low.prescale));
  assign ps_tick[1] = in_tick[1] & (ps_high_reg >= ps_limit(c_high.prescale));

  // Period comparisons
  assign match_low = (count_low_reg == period_low_reg);
  assign match_high = (count_high_reg == period_high_reg);
  assign match_pair = match_low & match_high;

  // Counters: a match is held one tick, then the count restarts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_low_reg <= 16'h0000;
      count_high_reg <= 16'h0000;
      clear_low_reg <= 1'b0;
      clear_high_reg <= 1'b0;
    end else if (mode == ctp_pkg::CTP_PAIRED) begin
      clear_high_reg <= 1'b0;
      // A counter write drops a pending restart, so a stale match cannot replay
      if (wr && paddr == ctp_pkg::OFS_COUNT_LOW) begin
        count_low_reg <= pwdata[15:0];
        clear_low_reg <= 1'b0;
      end else if (wr && paddr == ctp_pkg::OFS_COUNT_HIGH) begin
        count_high_reg <= pwdata[15:0];
        clear_low_reg <= 1'b0;
      end else if (ps_tick[0]) begin
        if (clear_low_reg) begin
          count_low_reg <= 16'h0000;
          count_high_reg <= 16'h0000;
          clear_low_reg <= 1'b0;
        end else begin
          // Carry from low word into high word
          {count_high_reg, count_low_reg} <=
            32'({count_high_reg, count_low_reg} + 32'h1);
          clear_low_reg <= 1'b0;
        end
      end else if (match_pair && c_low.run) begin
        clear_low_reg <= 1'b1;
      end
    end else begin
      if (wr && paddr == ctp_pkg::OFS_COUNT_LOW) begin
        count_low_reg <= pwdata[15:0];
        clear_low_reg <= 1'b0;
      end else if (ps_tick[0]) begin
        count_low_reg <= clear_low_reg ? 16'h0000 : count_low_reg + 16'h0001;
        clear_low_reg <= 1'b0;
      end else if (match_low && c_low.run) begin
        clear_low_reg <= 1'b1;
      end
      if (wr && paddr == ctp_pkg::OFS_COUNT_HIGH) begin
        count_high_reg <= pwdata[15:0];
        clear_high_reg <= 1'b0;
      end else if (ps_tick[1]) begin
        count_high_reg <= clear_high_reg ? 16'h0000 : count_high_reg + 16'h0001;
        clear_high_reg <= 1'b0;
      end else if (match_high && c_high.run) begin
        clear_high_reg <= 1'b1;
      end
    end
  end

  // Match event fires once, on the cycle the clear is armed
  always_comb begin
    set_flag = 2'b00;
    if (mode == ctp_pkg::CTP_PAIRED) begin
      set_flag[1] = match_pair & c_low.run & ~clear_low_reg & ~ps_tick[0];
    end else begin
      set_flag[0] = match_low & c_low.run & ~clear_low_reg & ~ps_tick[0];
      set_flag[1] = match_high & c_high.run & ~clear_high_reg & ~ps_tick[1];
    end
  end

  // Control, period and interrupt registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_ctrl_reg <= ctp_pkg::CTRL_RESET;
      high_ctrl_reg <= ctp_pkg::CTRL_RESET;
      period_low_reg <= ctp_pkg::PERIOD_RESET;
      period_high_reg <= ctp_pkg::PERIOD_RESET;
      enable_reg <= 2'h0;
      prio_reg <= 6'h00;
    end else if (wr && pstrb[1:0] == 2'h3) begin
      case (paddr)
        ctp_pkg::OFS_LOW_CTRL: low_ctrl_reg <= pwdata[15:0] & ctp_pkg::LOW_CTRL_MASK;
        ctp_pkg::OFS_HIGH_CTRL: high_ctrl_reg <= pwdata[15:0] & ctp_pkg::HIGH_CTRL_MASK;
        ctp_pkg::OFS_PERIOD_LOW: period_low_reg <= pwdata[15:0];
        ctp_pkg::OFS_PERIOD_HIGH: period_high_reg <= pwdata[15:0];
        ctp_pkg::OFS_IRQ_ENABLE: enable_reg <= pwdata[1:0];
        ctp_pkg::OFS_IRQ_PRIORITY: prio_reg <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 2'h0;
    end else if (wr && paddr == ctp_pkg::OFS_IRQ_FLAGS) begin
      flag_reg <= (flag_reg & ~pwdata[1:0]) | set_flag;
    end else begin
      flag_reg <= flag_reg | set_flag;
    end
  end

  // ADC trigger only in pair mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= (mode == ctp_pkg::CTP_PAIRED) & set_flag[1];
    end
  end

  // Read mux, registered for the access phase
  always_comb begin
    prdata_next = 32'h0000_0000;
    case (paddr)
      ctp_pkg::OFS_LOW_CTRL: prdata_next[15:0] = low_ctrl_reg;
      ctp_pkg::OFS_HIGH_CTRL: prdata_next[15:0] = high_ctrl_reg;
      ctp_pkg::OFS_COUNT_LOW: prdata_next[15:0] = count_low_reg;
      ctp_pkg::OFS_COUNT_HIGH: prdata_next[15:0] = count_high_reg;
      ctp_pkg::OFS_PERIOD_LOW: prdata_next[15:0] = period_low_reg;
      ctp_pkg::OFS_PERIOD_HIGH: prdata_next[15:0] = period_high_reg;
      ctp_pkg::OFS_IRQ_FLAGS: prdata_next[1:0] = flag_reg;
      ctp_pkg::OFS_IRQ_ENABLE: prdata_next[1:0] = enable_reg;
      ctp_pkg::OFS_IRQ_PRIORITY: prdata_next[5:0] = prio_reg;
      default: prdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      prdata <= prdata_next;
    end
  end

  // Interrupt requests and time bases
  assign irq_low = flag_reg[0] & enable_reg[0];
  assign irq_high = flag_reg[1] & enable_reg[1];
  assign irq_low_priority = prio_reg[2:0];
  assign irq_high_priority = prio_reg[5:3];
  assign base_low = '{count: count_low_reg, tick: ps_tick[0]};
  assign base_high = '{count: count_high_reg,
                       tick: (mode == ctp_pkg::CTP_PAIRED) ? 1'b0 : ps_tick[1]};

  // Checks; bus writes are masked out where a counter write would override a tick
  chk_pair_flag_high: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_reg[0]) |-> $past(mode) == ctp_pkg::CTP_SINGLE)
    else $error("low flag set by a paired match");
  chk_pair_match32: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(flag_reg[1]) && $past(mode) == ctp_pkg::CTP_PAIRED |->
      $past(count_high_reg) == period_high_reg && $past(count_low_reg) == period_low_reg)
    else $error("pair flag without a 32-bit period match");
  chk_adc_pair_only: assert property (@(posedge pclk) disable iff (!presetn)
    adc_trigger |-> $past(mode) == ctp_pkg::CTP_PAIRED)
    else $error("adc trigger outside pair mode");
  chk_adc_follows: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_PAIRED && set_flag[1] |=> adc_trigger)
    else $error("pair match gave no adc trigger");
  chk_restart_zero: assert property (@(posedge pclk) disable iff (!presetn)
    clear_low_reg && ps_tick[0] && !wr |=> count_low_reg == 16'h0000)
    else $error("count did not restart after match");
  chk_stopped_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !c_low.run && !wr |=> $stable(count_low_reg))
    else $error("low count moved while stopped");
  chk_high_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_PAIRED && !ps_tick[0] && !wr |=> $stable(count_high_reg))
    else $error("high word moved without low tick");
  chk_carry_word: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_PAIRED && ps_tick[0] && !clear_low_reg && !wr &&
      count_low_reg == 16'hFFFF |=> count_high_reg == $past(count_high_reg) + 16'h0001)
    else $error("carry into high word lost");
  chk_single_step: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_SINGLE && ps_tick[0] && !clear_low_reg && !wr |=>
      count_low_reg == $past(count_low_reg) + 16'h0001)
    else $error("lone low count did not step");
  chk_high_step: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_SINGLE && ps_tick[1] && !clear_high_reg && !wr |=>
      count_high_reg == $past(count_high_reg) + 16'h0001)
    else $error("lone high count did not step");
  chk_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (low_ctrl_reg & ~ctp_pkg::LOW_CTRL_MASK) == 16'h0000)
    else $error("unimplemented control bit set");
  chk_idle_stop: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_idle && c_low.idle_stop |-> !in_tick[0])
    else $error("timer ticked in idle with idle stop");
  // Idle without the stop bit must leave the internal tick untouched
  chk_idle_runs: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_idle && c_low.run && !c_low.idle_stop && !c_low.src && !c_low.gate &&
      int_div_reg |-> in_tick[0])
    else $error("timer stalled in idle without idle stop");
  chk_gate_shut: assert property (@(posedge pclk) disable iff (!presetn)
    !c_low.src && c_low.gate && !gate_s2[0] |-> !in_tick[0])
    else $error("timer ticked with the gate shut");
  // Both sources give isolated pulses; a doubled tick could step the count past its period without a match
  chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    ps_tick[0] |=> !ps_tick[0])
    else $error("prescaled tick on two cycles in a row");
  cov_idle_run: cover property (@(posedge pclk) disable iff (!presetn)
    cpu_idle && in_tick[0]);
  cov_pair_match: cover property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_PAIRED && set_flag[1]);
  cov_single_low: cover property (@(posedge pclk) disable iff (!presetn) set_flag[0]);
  cov_single_high: cover property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_SINGLE && set_flag[1]);
  cov_carry: cover property (@(posedge pclk) disable iff (!presetn)
    mode == ctp_pkg::CTP_PAIRED && ps_tick[0] && count_low_reg == 16'hFFFF);

endmodule // ctp_timer_pair

//--- src/ctp_pkg.sv
// Purpose: Constants and types for the cascadable timer pair.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes: Control words are 16 bits wide in the low lanes; upper bits read zero.
// How it works
// - Two 16-bit timers run independently, without asynchronous counter mode.
// - Timers can join into one 32-bit timer or synchronous counter.
// - Pair-mode bit selects 32-bit operation; software sets it first.
// - Low timer forms the low word, high timer the high word.
// - In pair mode the high control register bits are ignored.
// - In pair mode the low timer clock and gate drive the counter.
// - In pair mode a 32-bit count versus period match raises an interrupt.
// - Pair match sets the high timer flag with its enable and priority.
// - Software loads high period with high word, low period with low word.
// - Count pair always reads as high word and low word registers.
// - Run bit 15 starts or stops the pair or the single timer.
// - Clearing pair mode returns to two 16-bit timers.
// - Alone, each timer matches its own period and raises its own interrupt.
// - Each timer selects internal or external clock and gated accumulation.
// - In pair mode the low timer prescale field sets the ratio.
// - Timers keep operating in Sleep, and in Idle unless the idle-stop bit is set.
// - ADC trigger comes only from the cascaded pair.
// - Both timers offer their count as capture and compare time bases.
// - Prescale 11 is 1:256, 10 is 1:64, 01 is 1:8, 00 is 1:1.
// - Pair-mode is low control bit 3; high run, gate, prescale, source ignored.
// - Idle-stop bit set stops the timer on Idle entry; clear keeps it running.
// - Source clear counts internal Fosc/2; set counts the external pin.
package ctp_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_LOW_CTRL = 8'h00;
  localparam logic [7:0] OFS_HIGH_CTRL = 8'h04;
  localparam logic [7:0] OFS_COUNT_LOW = 8'h08;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h0C;
  localparam logic [7:0] OFS_PERIOD_LOW = 8'h10;
  localparam logic [7:0] OFS_PERIOD_HIGH = 8'h14;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  localparam logic [7:0] OFS_IRQ_PRIORITY = 8'h20;
  // Control field positions
  localparam int BIT_RUN = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PAIR = 3;
  localparam int BIT_SRC = 1;
  // Writable bits of each control register
  localparam logic [15:0] LOW_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] HIGH_CTRL_MASK = 16'hA072;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  // Prescale ratios
  localparam logic [1:0] PS_1 = 2'h0;
  localparam logic [1:0] PS_8 = 2'h1;
  localparam logic [1:0] PS_64 = 2'h2;
  localparam logic [1:0] PS_256 = 2'h3;
  localparam logic [7:0] DIV_1 = 8'h00;
  localparam logic [7:0] DIV_8 = 8'h07;
  localparam logic [7:0] DIV_64 = 8'h3F;
  localparam logic [7:0] DIV_256 = 8'hFF;
  // Internal instruction clock is pclk halved
  localparam logic [0:0] INT_DIV = 1'h1;

  typedef enum logic [1:0] {
    CTP_SINGLE = 2'b00,
    CTP_PAIRED = 2'b01
  } ctp_mode_e;

  // Decoded control word of one timer
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic gate;
    logic [1:0] prescale;
    logic src;
  } ctp_ctrl_s;

  // Per-timer outputs toward capture and compare
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } ctp_base_s;
endpackage

//--- test/ctp_timer_pair_test.sv
// Purpose: Self-checking bench for the cascadable timer pair over APB.
// Assumes: Zero-wait slave; internal count tick is every second pclk.
// Notes: Polled outputs are sampled on the falling edge, where they have settled; bus reads take prdata just after the rising edge.
`timescale 1ns/10ps
module ctp_timer_pair_test;
  // Count a comparison and report a mismatch at once
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } ctp_row_s;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, r1;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, irq_low, irq_high, adc_trigger;
  logic ext_clk_low = 1'b0, ext_gate_low = 1'b0, cpu_idle = 1'b0;
  logic [2:0] irq_low_priority, irq_high_priority;
  ctp_pkg::ctp_base_s base_low, base_high;
  logic ih, il, hw, ht, mx, trig;
  int fail_count = 0, n_checks = 0, n, k, na, dv;
  // Write, then read back what the register keeps
  ctp_row_s rows [0:7] = '{'{8'h00, 32'h0000FFFF, 32'h0000A07A},
    '{8'h04, 32'h0000FFFF, 32'h0000A072}, '{8'h00, 32'hFFFF0000, 32'h00000000},
    '{8'h10, 32'h00001234, 32'h00001234}, '{8'h14, 32'h0000ABCD, 32'h0000ABCD},
    '{8'h1C, 32'h00000003, 32'h00000003}, '{8'h20, 32'h0000002B, 32'h0000002B},
    '{8'h24, 32'h0000FFFF, 32'h00000000}};
  logic [7:0] ra [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
  logic [31:0] re [0:6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0};

  ctp_timer_pair dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_clk_low(ext_clk_low), .ext_clk_high(1'b0),
    .ext_gate_low(ext_gate_low), .ext_gate_high(1'b0), .cpu_idle(cpu_idle),
    .irq_low(irq_low), .irq_high(irq_high), .irq_low_priority(irq_low_priority),
    .irq_high_priority(irq_high_priority), .base_low(base_low), .base_high(base_high),
    .adc_trigger(adc_trigger));

  // Free-running bus clock
  always #50 pclk = ~pclk;

  task automatic cyc(input int c);
    repeat (c) @(posedge pclk);
  endtask

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) fail_count++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    apb(1'b0, a, 32'h0, q);
  endtask

  // Single place where the run ends
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the expected length of the run
  initial begin
    #(100 * 30000);
    fail_count++;
    report_and_stop();
  end

  initial begin
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, r);
      `CHK("reg readback", rows[i].e, r)
    end
    `CHK("priority", 6'h2B, {irq_high_priority, irq_low_priority})
    `CHK("slave error", 1'b0, pslverr)
    // Reset in mid-run must restore the control, count, period and priority registers
    presetn <= 1'b0;
    cyc(2);
    presetn <= 1'b1;
    cyc(1);
    foreach (ra[i]) begin
      rd(ra[i], r);
      `CHK("reset value", re[i], r)
    end
    // Every prescale code: ticks in a window of three tick periods
    for (int p = 0; p < 4; p++) begin
      dv = (p == 0) ? 1 : (p == 1) ? 8 : (p == 2) ? 64 : 256;
      wr(8'h00, 32'h8000 | (32'(p) << 4));
      cyc(2 * dv + 4);
      k = 0;
      repeat (6 * dv) begin
        @(negedge pclk);
        if (base_low.tick === 1'b1) k++;
      end
      `CHK("prescale ticks", 3, k)
      wr(8'h00, 32'h0);
    end
    // Lone low timer: match, wrap to zero, no pair trigger
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h3);
    wr(8'h1C, 32'h1);
    wr(8'h00, 32'h8000);
    n = 0;
    while (irq_low !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    `CHK("low irq", 1'b1, irq_low)
    mx = 1'b0;
    trig = 1'b0;
    repeat (40) begin
      @(negedge pclk);
      if (base_low.count > 16'h0003) mx = 1'b1;
      if (adc_trigger === 1'b1 || irq_high === 1'b1) trig = 1'b1;
    end
    `CHK("wrap at period", 1'b0, mx)
    `CHK("no lone trigger", 1'b0, trig)
    wr(8'h00, 32'h0);
    wr(8'h18, 32'h1);
    rd(8'h18, r);
    `CHK("flag cleared", 32'h0, r)
    // Pair: high control asks for run and 1:256, which must be ignored
    wr(8'h00, 32'h8);
    wr(8'h04, 32'h8070);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h1);
    wr(8'h08, 32'hFFFC);
    wr(8'h0C, 32'h0);
    wr(8'h1C, 32'h3);
    wr(8'h00, 32'h8008);
    {ih, il, hw, ht} = 4'h0;
    na = 0;
    repeat (40) begin
      @(negedge pclk);
      if (irq_high === 1'b1) ih = 1'b1;
      if (irq_low === 1'b1) il = 1'b1;
      if (base_high.count === 16'h0001) hw = 1'b1;
      if (base_high.tick === 1'b1) ht = 1'b1;
      if (adc_trigger === 1'b1) na++;
    end
    `CHK("pair match irq", 1'b1, ih)
    `CHK("low flag quiet", 1'b0, il)
    `CHK("carry to high", 1'b1, hw)
    `CHK("high tick idle", 1'b0, ht)
    `CHK("one adc pulse", 1, na)
    wr(8'h00, 32'h8);
    rd(8'h0C, r);
    `CHK("high word wrapped", 32'h0, r)
    rd(8'h08, r1);
    cyc(10);
    rd(8'h08, r);
    `CHK("stopped count", r1, r)
    // Back to two timers: the high timer runs on its own control
    wr(8'h00, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h14, 32'h2);
    wr(8'h18, 32'h3);
    rd(8'h18, r);
    `CHK("flags cleared", 32'h0, r)
    wr(8'h04, 32'h8000);
    n = 0;
    while (irq_high !== 1'b1 && n < 100) begin
      @(negedge pclk);
      n++;
    end
    `CHK("high lone irq", 1'b1, irq_high)
    wr(8'h04, 32'h0);
    // Idle: stop bit set halts, clear keeps counting
    wr(8'h00, 32'hA000);
    cpu_idle <= 1'b1;
    cyc(4);
    rd(8'h08, r1);
    cyc(20);
    rd(8'h08, r);
    `CHK("idle halt", r1, r)
    wr(8'h00, 32'h8000);
    rd(8'h08, r1);
    cyc(20);
    rd(8'h08, r);
    `CHK("idle run", 1'b1, r !== r1)
    cpu_idle <= 1'b0;
    // External pin: five rising edges give five counts
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h10, 32'hFFFF);
    wr(8'h00, 32'h8002);
    repeat (5) begin
      ext_clk_low <= 1'b1;
      cyc(4);
      ext_clk_low <= 1'b0;
      cyc(4);
    end
    rd(8'h08, r);
    `CHK("pin count", 32'h5, r)
    // Gated accumulation counts only while the gate is high
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h8040);
    cyc(20);
    rd(8'h08, r);
    `CHK("gate shut", 32'h0, r)
    ext_gate_low <= 1'b1;
    cyc(20);
    rd(8'h08, r);
    `CHK("gate open", 1'b1, r[15:0] != 16'h0000)
    report_and_stop();
  end
endmodule // ctp_timer_pair_test
